// ### bench/dsc_osc_model.sv
// Behavioural crystal and RC oscillator sources
`timescale 1ns/1ps
module dsc_osc_model (
  input  wire logic xtal_en_i,
  input  wire logic rc_en_i,
  output logic      xtal_clk_o,
  output logic      rc_clk_o
);
  logic xtal_run;
  logic rc_run;

  // Free phases: crystal 10 MHz, RC 6.25 MHz, off the core edges
  initial begin
    xtal_run = 1'b0;
    #3;
    forever #50 xtal_run = ~xtal_run;
  end

  initial begin
    rc_run = 1'b0;
    #7;
    forever #80 rc_run = ~rc_run;
  end

  // A stopped oscillator holds its output low
  assign xtal_clk_o = xtal_run & xtal_en_i;
  assign rc_clk_o   = rc_run & rc_en_i;
endmodule : dsc_osc_model

// ### bench/tb_dsc_clock_prescaler.sv
// Self-checking bench of the dual source clock prescaler
`timescale 1ns/1ps
module tb_dsc_clock_prescaler;
  import dsc_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       wr  = 1'b0;
  logic       rd  = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic       xclk, rclk, xen, ren, ck, rise, mcy;
  int         bad_count = 0;
  int         n_tests = 0;

  always #5 clk = ~clk;

  dsc_clock_prescaler i_dsc_clock_prescaler (
    .core_clk_i(clk), .reset_i(rst), .crystal_clk_i(xclk), .rc_clk_i(rclk),
    .addr_i(addr), .wr_data_i(wdata), .wr_i(wr), .rd_i(rd),
    .rd_data_o(rdata), .crystal_osc_enable_o(xen), .rc_osc_enable_o(ren),
    .ck_out_o(ck), .ck_rise_o(rise), .machine_cycle_o(mcy));

  dsc_osc_model i_dsc_osc_model (
    .xtal_en_i(xen), .rc_en_i(ren), .xtal_clk_o(xclk), .rc_clk_o(rclk));

  task report_and_stop;
    $display("tests %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chkn(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      bad_count++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chkn

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk8(rdata, exp);
    @(posedge clk);
    #1;
    chk8(rdata, 8'h00);
  endtask : rd_reg

  // Cycles from now to the next pulse of ck_rise_o or machine_cycle_o
  task automatic wait_hit(input bit mc, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (((mc ? mcy : rise) !== 1'b1) && n < 6000);
    if (n >= 6000) begin
      bad_count++;
      $display("[ERR] %0t no output clock edge", $time);
      report_and_stop();
    end
  endtask : wait_hit

  // Skips to the next pulse and one settling interval, then measures one full interval
  task automatic gap(input bit mc, input int exp);
    int n;
    wait_hit(mc, n);
    wait_hit(mc, n);
    wait_hit(mc, n);
    chkn(n, exp);
  endtask : gap

  task automatic count_rise(input int cycles, output int k);
    k = 0;
    repeat (cycles) begin
      @(posedge clk);
      #1;
      if (rise === 1'b1) k++;
    end
  endtask : count_rise

  task automatic t_reset;
    rd_reg(CTRL_ADDR, 8'h01);
    rd_reg(SEL_ADDR, 8'h01);
    rd_reg(RELOAD_ADDR, 8'hff);
    rd_reg(MODE_ADDR, 8'h00);
    chk8({6'h00, ren, xen}, 8'h01);
    gap(1'b0, 20);
    gap(1'b1, 120);
  endtask : t_reset

  task automatic t_divide;
    wr_reg(RELOAD_ADDR, 8'hfe);
    gap(1'b0, 40);
    gap(1'b1, 240);
    wr_reg(RELOAD_ADDR, 8'h00);
    rd_reg(RELOAD_ADDR, 8'h00);
    gap(1'b0, 5120);
    wr_reg(RELOAD_ADDR, 8'hff);
  endtask : t_divide

  task automatic t_bypass;
    wr_reg(MODE_ADDR, 8'h01);
    gap(1'b0, 10);
    gap(1'b1, 60);
    wr_reg(MODE_ADDR, 8'h00);
    gap(1'b0, 20);
  endtask : t_bypass

  task automatic t_gate;
    int k;
    wr_reg(CTRL_ADDR, 8'h00);
    #1;
    chk8({7'h00, xen}, 8'h00);
    repeat (10) @(posedge clk);
    count_rise(300, k);
    chkn(k, 0);
    wr_reg(CTRL_ADDR, 8'h01);
  endtask : t_gate

  task automatic t_switch;
    int k;
    wr_reg(CTRL_ADDR, 8'h03);
    #1;
    chk8({7'h00, ren}, 8'h01);
    repeat (50) @(posedge clk);
    wait_hit(1'b0, k);
    wr_reg(SEL_ADDR, 8'h00);
    @(posedge clk);
    #1;
    chk8({7'h00, ck}, 8'h01);
    count_rise(8, k);
    chkn(k, 0);
    gap(1'b0, 32);
    rd_reg(STATUS_ADDR, 8'h02);
    wr_reg(CTRL_ADDR, 8'h02);
    gap(1'b0, 32);
    wr_reg(CTRL_ADDR, 8'h01);
    count_rise(300, k);
    chkn(k, 0);
    wr_reg(CTRL_ADDR, 8'h03);
    repeat (50) @(posedge clk);
    wr_reg(SEL_ADDR, 8'h01);
    gap(1'b0, 20);
  endtask : t_switch

  task automatic t_bus;
    rd_reg(8'h90, 8'h00);
    wr_reg(8'h90, 8'hff);
    rd_reg(CTRL_ADDR, 8'h03);
    wr_reg(CTRL_ADDR, 8'h07);
    rd_reg(CTRL_ADDR, 8'h07);
    wr_reg(CTRL_ADDR, 8'h01);
  endtask : t_bus

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_divide();
    t_bypass();
    t_gate();
    t_switch();
    t_bus();
    report_and_stop();
  end
endmodule : tb_dsc_clock_prescaler

// ### hdl/dsc_clock_prescaler.sv
// Clock source selection, synchronised switch and programmable prescaler
`timescale 1ns/1ps
module dsc_clock_prescaler
  import dsc_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              reset_i,
  input  wire logic              crystal_clk_i,
  input  wire logic              rc_clk_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rd_data_o,
  output logic                   crystal_osc_enable_o,
  output logic                   rc_osc_enable_o,
  output logic                   ck_out_o,
  output logic                   ck_rise_o,
  output logic                   machine_cycle_o
);

  logic [2:0] ctrl_reg;
  logic       source_select_reg;
  logic [7:0] clock_divider_reload_reg;
  logic       double_speed_bypass_reg;
  logic       active_sel_reg;
  logic [1:0] xtal_sync_reg;
  logic [1:0] rc_sync_reg;
  logic       src_prev_reg;
  logic [7:0] cnt_reg;
  logic       ck_out_reg;
  logic [2:0] mc_cnt_reg;
  logic       ck_rise_reg;
  logic       mc_reg;
  logic [DATA_W-1:0] rd_data_reg;

  logic       xtal_en;
  logic       rc_en;
  logic       src_level;
  logic       src_rise;
  logic       src_fall;
  logic       switch_w;
  logic       pending;
  logic       running;
  logic [8:0] half;
  logic       half_done;
  logic       ck_out_next;
  logic       reload_wr;

  assign xtal_en   = ctrl_reg[CTRL_XTAL_EN_BIT];
  assign rc_en     = ctrl_reg[CTRL_RC_EN_BIT];
  assign reload_wr = wr_i && addr_i == RELOAD_ADDR;

  // Oscillator enables driven straight from the control bits
  assign crystal_osc_enable_o = xtal_en;
  assign rc_osc_enable_o      = rc_en;

  // Register writes
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ctrl_reg                 <= CTRL_RESET;
      source_select_reg        <= SEL_RESET;
      clock_divider_reload_reg <= RELOAD_RESET;
      double_speed_bypass_reg  <= X2_RESET;
    end else if (wr_i) begin
      case (addr_i)
        CTRL_ADDR:   ctrl_reg <= wr_data_i[2:0];
        SEL_ADDR:    source_select_reg <= wr_data_i[SEL_BIT];
        RELOAD_ADDR: clock_divider_reload_reg <= wr_data_i;
        MODE_ADDR:   double_speed_bypass_reg <= wr_data_i[MODE_X2_BIT];
        default: ;
      endcase
    end
  end

  // Register reads, data one cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rd_data_reg <= '0;
    end else if (rd_i) begin
      case (addr_i)
        CTRL_ADDR:   rd_data_reg <= {5'h00, ctrl_reg};
        SEL_ADDR:    rd_data_reg <= {7'h00, source_select_reg};
        RELOAD_ADDR: rd_data_reg <= clock_divider_reload_reg;
        MODE_ADDR:   rd_data_reg <= {7'h00, double_speed_bypass_reg};
        STATUS_ADDR: rd_data_reg <= {5'h00, pending, running, active_sel_reg};
        default:     rd_data_reg <= '0;
      endcase
    end else begin
      rd_data_reg <= '0;
    end
  end
  assign rd_data_o = rd_data_reg;

  // Two stage synchronisers for both source pins
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      xtal_sync_reg <= 2'h0;
      rc_sync_reg   <= 2'h0;
    end else begin
      xtal_sync_reg <= {xtal_sync_reg[0], crystal_clk_i};
      rc_sync_reg   <= {rc_sync_reg[0], rc_clk_i};
    end
  end

  // Source choice gated by the enable of the chosen source
  assign running   = active_sel_reg ? xtal_en : rc_en;
  assign src_level = active_sel_reg ? (xtal_sync_reg[1] & xtal_en)
                                    : (rc_sync_reg[1] & rc_en);
  assign src_rise  = src_level & ~src_prev_reg;
  assign src_fall  = ~src_level & src_prev_reg;

  // Switch source only while the output is low
  assign pending  = source_select_reg != active_sel_reg;
  assign switch_w = pending && !ck_out_reg;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      active_sel_reg <= SEL_RESET;
      src_prev_reg   <= 1'b0;
    end else begin
      if (switch_w) begin
        active_sel_reg <= source_select_reg;
      end
      src_prev_reg <= switch_w ? 1'b1 : src_level;
    end
  end

  // Half period of the divided clock is 256 - reload source periods
  assign half      = HALF_BASE - {1'b0, clock_divider_reload_reg};
  assign half_done = ({1'b0, cnt_reg} + 9'h001) >= half;

  always_comb begin
    ck_out_next = ck_out_reg;
    if (pending && !ck_out_reg) begin
      ck_out_next = 1'b0;
    end else if (double_speed_bypass_reg) begin
      if (src_rise) begin
        ck_out_next = 1'b1;
      end else if (src_fall) begin
        ck_out_next = 1'b0;
      end
    end else if (src_rise && half_done) begin
      ck_out_next = ~ck_out_reg;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cnt_reg    <= 8'h00;
      ck_out_reg <= 1'b0;
    end else begin
      ck_out_reg <= ck_out_next;
      if (switch_w || reload_wr || double_speed_bypass_reg) begin
        cnt_reg <= 8'h00;
      end else if (src_rise) begin
        cnt_reg <= half_done ? 8'h00 : cnt_reg + 8'h01;
      end
    end
  end
  assign ck_out_o = ck_out_reg;

  // Machine cycle strobe every six output clock periods
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mc_cnt_reg  <= 3'h0;
      ck_rise_reg <= 1'b0;
      mc_reg      <= 1'b0;
    end else begin
      ck_rise_reg <= ck_out_next & ~ck_out_reg;
      mc_reg      <= 1'b0;
      if (ck_out_next & ~ck_out_reg) begin
        if (mc_cnt_reg == MC_PERIODS - 3'h1) begin
          mc_cnt_reg <= 3'h0;
          mc_reg     <= 1'b1;
        end else begin
          mc_cnt_reg <= mc_cnt_reg + 3'h1;
        end
      end
    end
  end
  assign ck_rise_o       = ck_rise_reg;
  assign machine_cycle_o = mc_reg;

  // Checks
  property p_reset_values;
    @(posedge core_clk_i) ($past(reset_i) && !reset_i) |->
      clock_divider_reload_reg == RELOAD_RESET &&
      double_speed_bypass_reg == X2_RESET;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("divider or double speed wrong after reset");

  property p_xtal_gated;
    @(posedge core_clk_i) disable iff (reset_i)
      (active_sel_reg && !xtal_en)[*2] |-> !src_rise;
  endproperty
  a_xtal_gated: assert property (p_xtal_gated)
    else $error("edge seen from disabled crystal");

  property p_rc_gated;
    @(posedge core_clk_i) disable iff (reset_i)
      (!active_sel_reg && !rc_en)[*2] |-> !src_rise;
  endproperty
  a_rc_gated: assert property (p_rc_gated)
    else $error("edge seen from disabled rc oscillator");

  property p_cnt_bound;
    @(posedge core_clk_i) disable iff (reset_i)
      !double_speed_bypass_reg |-> {1'b0, cnt_reg} < half;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound)
    else $error("prescaler count beyond half period");

  property p_toggle_on_edge;
    @(posedge core_clk_i) disable iff (reset_i)
      (!$past(double_speed_bypass_reg) && !$past(pending) &&
       $changed(ck_out_reg)) |-> $past(src_rise) && $past(half_done);
  endproperty
  a_toggle_on_edge: assert property (p_toggle_on_edge)
    else $error("divided clock toggled off a count end");

  property p_bypass_follow;
    @(posedge core_clk_i) disable iff (reset_i)
      (double_speed_bypass_reg && src_rise && !pending) |=> ck_out_reg;
  endproperty
  a_bypass_follow: assert property (p_bypass_follow)
    else $error("bypass output missed a source edge");

  property p_machine_cycle;
    @(posedge core_clk_i) disable iff (reset_i)
      machine_cycle_o |-> ck_rise_o && mc_cnt_reg == 3'h0;
  endproperty
  a_machine_cycle: assert property (p_machine_cycle)
    else $error("machine cycle strobe out of step");

  property p_switch_low;
    @(posedge core_clk_i) disable iff (reset_i)
      $changed(active_sel_reg) |-> !ck_out_reg && !$past(ck_out_reg);
  endproperty
  a_switch_low: assert property (p_switch_low)
    else $error("source switched while output high");

  property p_select_follow;
    @(posedge core_clk_i) disable iff (reset_i)
      (pending && !ck_out_reg) |=> active_sel_reg == $past(source_select_reg);
  endproperty
  a_select_follow: assert property (p_select_follow)
    else $error("active source did not follow select");

  property p_dead_select;
    @(posedge core_clk_i) disable iff (reset_i)
      (!running)[*2] |-> !src_rise;
  endproperty
  a_dead_select: assert property (p_dead_select)
    else $error("clock from a disabled selected source");

  property p_xtal_frozen;
    @(posedge core_clk_i) disable iff (reset_i)
      (active_sel_reg && !xtal_en && !pending)[*3] |-> $stable(ck_out_reg);
  endproperty
  a_xtal_frozen: assert property (p_xtal_frozen)
    else $error("output moved with the crystal disabled");

  property p_rc_frozen;
    @(posedge core_clk_i) disable iff (reset_i)
      (!active_sel_reg && !rc_en && !pending)[*3] |-> $stable(ck_out_reg);
  endproperty
  a_rc_frozen: assert property (p_rc_frozen)
    else $error("output moved with the rc oscillator disabled");

  property p_no_runt;
    @(posedge core_clk_i) disable iff (reset_i)
      (pending && ck_out_reg && !src_rise && !src_fall) |=> ck_out_reg;
  endproperty
  a_no_runt: assert property (p_no_runt)
    else $error("high phase cut short by a source switch");

  property p_reload_clear;
    @(posedge core_clk_i) disable iff (reset_i)
      reload_wr |=> cnt_reg == 8'h00;
  endproperty
  a_reload_clear: assert property (p_reload_clear)
    else $error("prescaler count not cleared by a reload write");

  property p_rise_pulse;
    @(posedge core_clk_i) disable iff (reset_i)
      ck_rise_o |-> ck_out_o && !$past(ck_out_o);
  endproperty
  a_rise_pulse: assert property (p_rise_pulse)
    else $error("rise strobe without an output rising edge");

  property p_rd_idle;
    @(posedge core_clk_i) disable iff (reset_i)
      !$past(rd_i) |-> rd_data_o == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read answer");

  c_switch:  cover property (@(posedge core_clk_i) disable iff (reset_i)
    $changed(active_sel_reg));
  c_bypass:  cover property (@(posedge core_clk_i) disable iff (reset_i)
    double_speed_bypass_reg && ck_rise_o);
  c_divided: cover property (@(posedge core_clk_i) disable iff (reset_i)
    !double_speed_bypass_reg && machine_cycle_o);
  c_gated:   cover property (@(posedge core_clk_i) disable iff (reset_i)
    !running && !pending);
  c_slowest: cover property (@(posedge core_clk_i) disable iff (reset_i)
    half == HALF_BASE && machine_cycle_o);

endmodule : dsc_clock_prescaler

// ### hdl/dsc_pkg.sv
// Constants, register map and reset values of the dual source clock prescaler
package dsc_pkg;

  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 8;

  localparam logic [7:0]  CTRL_ADDR         = 8'h8f;
  localparam logic [7:0]  SEL_ADDR          = 8'h8c;
  localparam logic [7:0]  RELOAD_ADDR       = 8'h8d;
  localparam logic [7:0]  MODE_ADDR         = 8'h8e;
  localparam logic [7:0]  STATUS_ADDR       = 8'h8b;

  localparam int          CTRL_XTAL_EN_BIT  = 0;
  localparam int          CTRL_RC_EN_BIT    = 1;
  localparam int          CTRL_SUBCLK_BIT   = 2;
  localparam int          SEL_BIT           = 0;
  localparam int          MODE_X2_BIT       = 0;
  localparam int          STAT_ACTIVE_BIT   = 0;
  localparam int          STAT_RUNNING_BIT  = 1;
  localparam int          STAT_PENDING_BIT  = 2;

  localparam logic [2:0]  CTRL_RESET        = 3'h1;
  localparam logic        SEL_RESET         = 1'b1;
  localparam logic [7:0]  RELOAD_RESET      = 8'hff;
  localparam logic        X2_RESET          = 1'b0;

  localparam logic [8:0]  HALF_BASE         = 9'h100;
  localparam logic [2:0]  MC_PERIODS        = 3'h6;

endpackage : dsc_pkg
